// ---- src/scp_pkg.sv ----
/*
 * Shared constants for the system clock source and PLL control block:
 * register offsets, field positions, reset values, mode codes, counts.
 * Assumes a Wishbone classic slave with 32-bit data and byte addressing.
 */
package scp_pkg;
    // register byte offsets
    localparam logic [3:0] ADR_PLL_CTRL = 4'h0;
    localparam logic [3:0] ADR_OSC_CTRL = 4'h4;
    localparam logic [3:0] ADR_FEATURES = 4'h8;

    // pll_block_control fields
    localparam int POST_RATIO_BIT = 7;
    localparam int MULT_EN_BIT = 6;
    localparam int POST_EN_BIT = 5;
    localparam int PRE_RATIO_BIT = 4;
    localparam logic [7:0] PLL_CTRL_RST = 8'h00;

    // osc_control_reg fields
    localparam int IDLE_EN_BIT = 7;
    localparam int RUN_DEFAULT_BIT = 3;
    localparam logic [7:0] OSC_CTRL_RST = 8'h00;

    // feature register fields
    localparam int FAILSAFE_BIT = 0;
    localparam int WATCHDOG_BIT = 1;
    localparam int TWO_SPEED_BIT = 2;
    localparam int TIMER_OSC_BIT = 3;
    localparam int CFG_LSB = 4;
    localparam logic [3:0] FEATURES_RST = 4'h0;

    // oscillator configuration field, bits 1:0, bit 2 is default select
    localparam logic [1:0] CFG_CRYSTAL = 2'h0;
    localparam logic [1:0] CFG_CRYSTAL_MULT = 2'h1;
    localparam logic [1:0] CFG_EXT_CLOCK = 2'h2;
    localparam logic [1:0] CFG_EXT_MULT = 2'h3;
    localparam int DEFAULT_SEL_BIT = 2;

    // sysclk_source_select codes
    localparam logic [1:0] SEL_DEFAULT = 2'h0;
    localparam logic [1:0] SEL_TIMER = 2'h1;
    localparam logic [1:0] SEL_PRIMARY = 2'h2;
    localparam logic [1:0] SEL_INTERNAL = 2'h3;

    // divider and multiplier figures
    localparam logic [2:0] MULT_FACTOR = 3'h5;
    localparam logic [1:0] DIV_NONE = 2'h1;
    localparam logic [1:0] DIV_TWO = 2'h2;
    localparam logic [1:0] DIV_THREE = 2'h3;

    // timing counts, in edges of the clock concerned
    localparam logic [1:0] OLD_CLK_EDGES = 2'h2;
    localparam logic [1:0] NEW_CLK_EDGES = 2'h3;
    localparam int OSC_START_EDGES = 1024;
    localparam logic [1:0] OUT_HALF_EDGES = 2'h2;

    typedef enum logic [1:0] {SRC_SLOW, SRC_TIMER, SRC_PRIMARY} scp_src_t;
    typedef enum logic [1:0] {SW_IDLE, SW_OLD, SW_NEW} scp_sw_state_t;
endpackage

// ---- src/scp_clock_ctrl.sv ----
/*
 * System clock source selection and PLL block control.
 * Software reaches the control registers over Wishbone classic. The
 * oscillator signals arrive from outside and are sampled on i_mclk; the
 * block models the clock tree as gates, enables and ratio outputs.
 */
// Local design decisions: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - external clock modes skip start-up wait
// - plain external mode drives input divided four
// - feedback off in external, on crystal
// - slow oscillator clocks configuration load
// - slow oscillator on when selected or needed
// - configuration bit picks default start source
// - pre-divider two/three, post-divider one/two/three
// - multiplier multiplies pre-divided clock by five
// - bit 7 selects post ratio
// - bit 6 enables multiplier
// - multiplier bit only in multiplied modes
// - bit 5 enables post-divider
// - bit 4 selects pre ratio
// - low four bits read zero
// - pre-divider bypassed when both others off
// - clock ratio follows configuration table
// - three sources, three-bit primary configuration
// - timer oscillator is secondary source
// - select field codes internal, primary, timer
// - select zero follows default configuration bit
// - switch pauses two old, three new edges
module scp_clock_ctrl #(
    parameter int START_EDGES = scp_pkg::OSC_START_EDGES
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // wishbone classic slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [3:0] i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    input wire logic [3:0] i_wb_sel,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    // configuration and power state
    input wire logic [2:0] i_osc_config,
    input wire logic i_sleep,
    // oscillator signals from outside
    input wire logic i_osc_in_pin,
    input wire logic i_timer_osc,
    input wire logic i_slow_internal_osc,
    // clock tree controls
    output logic o_osc_out_pin,
    output logic o_osc_out_oe_n,
    output logic o_feedback_en,
    output logic o_slow_osc_en,
    output logic o_config_loading,
    output logic o_primary_ready,
    output logic o_sysclk_run,
    output logic [1:0] o_active_src,
    output logic o_mult_en,
    output logic [1:0] o_pre_div,
    output logic [1:0] o_post_div
);
    localparam int SCW = $clog2(START_EDGES + 1);
    // pll_block_control keeps only bits 7:4, indexed from bit 4
    localparam int MULT_EN_IDX = scp_pkg::MULT_EN_BIT - 4;
    localparam int POST_IDX = scp_pkg::POST_RATIO_BIT - 4;
    localparam int POST_EN_IDX = scp_pkg::POST_EN_BIT - 4;
    localparam int PRE_IDX = scp_pkg::PRE_RATIO_BIT - 4;

    // input sampling, third stage only feeds edge detection
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic [2:0] sync3_reg;
    logic [2:0] rise;

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
            sync3_reg <= 3'h0;
        end else begin
            sync1_reg <= {i_osc_in_pin, i_timer_osc, i_slow_internal_osc};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end
    assign rise = sync2_reg & ~sync3_reg;

    // configuration captured after reset release, slow osc runs meanwhile
    logic cfg_loaded_reg;
    logic [2:0] cfg_reg;
    logic crystal_mode;
    logic multiplied_mode;

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cfg_loaded_reg <= 1'b0;
            cfg_reg <= 3'h0;
        end else if (!cfg_loaded_reg) begin
            cfg_loaded_reg <= 1'b1;
            cfg_reg <= i_osc_config;
        end
    end
    assign crystal_mode = (cfg_reg[1:0] == scp_pkg::CFG_CRYSTAL) ||
        (cfg_reg[1:0] == scp_pkg::CFG_CRYSTAL_MULT);
    assign multiplied_mode = (cfg_reg[1:0] == scp_pkg::CFG_CRYSTAL_MULT) ||
        (cfg_reg[1:0] == scp_pkg::CFG_EXT_MULT);

    // registers
    logic [3:0] pll_reg;
    logic [7:0] osc_reg;
    logic [3:0] feat_reg;
    logic wr_en;
    logic wr_lane;
    logic mult_eff;

    assign wr_en = i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack;
    assign wr_lane = wr_en && i_wb_sel[0];
    // multiplier bit is dead outside the multiplied modes
    assign mult_eff = pll_reg[MULT_EN_IDX] && multiplied_mode;

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pll_reg <= scp_pkg::PLL_CTRL_RST[7:4];
        end else if (wr_lane && i_wb_adr == scp_pkg::ADR_PLL_CTRL) begin
            pll_reg <= i_wb_dat[7:4];
        end
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            osc_reg <= scp_pkg::OSC_CTRL_RST;
        end else if (wr_lane && i_wb_adr == scp_pkg::ADR_OSC_CTRL) begin
            osc_reg[scp_pkg::IDLE_EN_BIT] <= i_wb_dat[scp_pkg::IDLE_EN_BIT];
            // timer source request ignored while its oscillator is off
            if (i_wb_dat[1:0] != scp_pkg::SEL_TIMER ||
                    feat_reg[scp_pkg::TIMER_OSC_BIT]) begin
                osc_reg[1:0] <= i_wb_dat[1:0];
            end
        end
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            feat_reg <= scp_pkg::FEATURES_RST;
        end else if (wr_lane && i_wb_adr == scp_pkg::ADR_FEATURES) begin
            feat_reg <= i_wb_dat[3:0];
        end
    end

    // requested source decode
    scp_pkg::scp_src_t target;
    always_comb begin
        target = scp_pkg::SRC_SLOW;
        if (!cfg_loaded_reg) begin
            target = scp_pkg::SRC_SLOW;
        end else begin
            case (osc_reg[1:0])
                scp_pkg::SEL_INTERNAL: target = scp_pkg::SRC_SLOW;
                scp_pkg::SEL_PRIMARY: target = scp_pkg::SRC_PRIMARY;
                scp_pkg::SEL_TIMER: target = scp_pkg::SRC_TIMER;
                default: begin
                    if (cfg_reg[scp_pkg::DEFAULT_SEL_BIT]) begin
                        target = scp_pkg::SRC_PRIMARY;
                    end else begin
                        target = scp_pkg::SRC_SLOW;
                    end
                end
            endcase
        end
    end

    // primary start-up: crystal waits for edges, external clock does not
    logic [SCW-1:0] start_cnt_reg;
    logic ready_reg;

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            start_cnt_reg <= '0;
            ready_reg <= 1'b0;
        end else if (!cfg_loaded_reg) begin
            start_cnt_reg <= '0;
            ready_reg <= 1'b0;
        end else if (!crystal_mode) begin
            ready_reg <= 1'b1;
        end else if (i_sleep) begin
            start_cnt_reg <= '0;
            ready_reg <= 1'b0;
        end else if (!ready_reg && rise[2]) begin
            if (start_cnt_reg == SCW'(START_EDGES - 1)) begin
                ready_reg <= 1'b1;
            end
            start_cnt_reg <= start_cnt_reg + SCW'(1);
        end
    end

    // glitch-free switch sequence
    scp_pkg::scp_sw_state_t sw_state_reg;
    scp_pkg::scp_src_t cur_reg;
    scp_pkg::scp_src_t next_reg;
    logic [1:0] sw_cnt_reg;
    logic cur_edge;
    logic next_edge;
    logic next_ok;

    function automatic logic src_edge(input scp_pkg::scp_src_t s,
                                      input logic [2:0] r);
        case (s)
            scp_pkg::SRC_PRIMARY: src_edge = r[2];
            scp_pkg::SRC_TIMER: src_edge = r[1];
            default: src_edge = r[0];
        endcase
    endfunction

    assign cur_edge = src_edge(cur_reg, rise);
    assign next_edge = src_edge(next_reg, rise);
    assign next_ok = (target != scp_pkg::SRC_PRIMARY) || ready_reg;

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sw_state_reg <= scp_pkg::SW_IDLE;
            cur_reg <= scp_pkg::SRC_SLOW;
            next_reg <= scp_pkg::SRC_SLOW;
            sw_cnt_reg <= 2'h0;
            o_sysclk_run <= 1'b0;
        end else begin
            case (sw_state_reg)
                scp_pkg::SW_IDLE: begin
                    o_sysclk_run <= !(cur_reg == scp_pkg::SRC_PRIMARY &&
                        !ready_reg);
                    if (target != cur_reg && next_ok) begin
                        next_reg <= target;
                        sw_cnt_reg <= 2'h0;
                        o_sysclk_run <= 1'b0;
                        sw_state_reg <= scp_pkg::SW_OLD;
                    end
                end
                scp_pkg::SW_OLD: begin
                    if (cur_edge) begin
                        if (sw_cnt_reg == scp_pkg::OLD_CLK_EDGES - 2'h1) begin
                            sw_cnt_reg <= 2'h0;
                            sw_state_reg <= scp_pkg::SW_NEW;
                        end else begin
                            sw_cnt_reg <= sw_cnt_reg + 2'h1;
                        end
                    end
                end
                scp_pkg::SW_NEW: begin
                    if (next_edge) begin
                        if (sw_cnt_reg == scp_pkg::NEW_CLK_EDGES - 2'h1) begin
                            cur_reg <= next_reg;
                            o_sysclk_run <= 1'b1;
                            sw_state_reg <= scp_pkg::SW_IDLE;
                        end else begin
                            sw_cnt_reg <= sw_cnt_reg + 2'h1;
                        end
                    end
                end
                default: sw_state_reg <= scp_pkg::SW_IDLE;
            endcase
        end
    end

    // divided output on the second oscillator pin
    logic [1:0] out_cnt_reg;
    logic ext_plain;
    assign ext_plain = cfg_loaded_reg &&
        cfg_reg[1:0] == scp_pkg::CFG_EXT_CLOCK;

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            out_cnt_reg <= 2'h0;
            o_osc_out_pin <= 1'b0;
            o_osc_out_oe_n <= 1'b1;
        end else begin
            o_osc_out_oe_n <= !ext_plain;
            if (!ext_plain) begin
                out_cnt_reg <= 2'h0;
                o_osc_out_pin <= 1'b0;
            end else if (rise[2]) begin
                // toggle every second input edge gives a quarter rate
                if (out_cnt_reg == scp_pkg::OUT_HALF_EDGES - 2'h1) begin
                    out_cnt_reg <= 2'h0;
                    o_osc_out_pin <= !o_osc_out_pin;
                end else begin
                    out_cnt_reg <= out_cnt_reg + 2'h1;
                end
            end
        end
    end

    // enables and clock tree ratios
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_feedback_en <= 1'b0;
            o_slow_osc_en <= 1'b1;
            o_config_loading <= 1'b1;
            o_primary_ready <= 1'b0;
            o_active_src <= scp_pkg::SEL_INTERNAL;
            o_mult_en <= 1'b0;
            o_pre_div <= scp_pkg::DIV_NONE;
            o_post_div <= scp_pkg::DIV_NONE;
        end else begin
            o_feedback_en <= cfg_loaded_reg && crystal_mode;
            o_slow_osc_en <= !cfg_loaded_reg ||
                cur_reg == scp_pkg::SRC_SLOW ||
                target == scp_pkg::SRC_SLOW ||
                feat_reg[scp_pkg::FAILSAFE_BIT] ||
                feat_reg[scp_pkg::WATCHDOG_BIT] ||
                feat_reg[scp_pkg::TWO_SPEED_BIT];
            o_config_loading <= !cfg_loaded_reg;
            o_primary_ready <= ready_reg;
            case (cur_reg)
                scp_pkg::SRC_PRIMARY: o_active_src <= scp_pkg::SEL_PRIMARY;
                scp_pkg::SRC_TIMER: o_active_src <= scp_pkg::SEL_TIMER;
                default: o_active_src <= scp_pkg::SEL_INTERNAL;
            endcase
            o_mult_en <= mult_eff;
            if (!mult_eff && !pll_reg[POST_EN_IDX]) begin
                o_pre_div <= scp_pkg::DIV_NONE;
            end else begin
                o_pre_div <= pll_reg[PRE_IDX] ? scp_pkg::DIV_TWO :
                    scp_pkg::DIV_THREE;
            end
            if (!pll_reg[POST_EN_IDX]) begin
                o_post_div <= scp_pkg::DIV_NONE;
            end else begin
                o_post_div <= pll_reg[POST_IDX] ? scp_pkg::DIV_TWO :
                    scp_pkg::DIV_THREE;
            end
        end
    end

    // bus answer one cycle after the request, unmapped reads give zero
    logic [7:0] rd_byte;
    logic run_default;
    assign run_default = cur_reg == scp_pkg::SRC_PRIMARY &&
        cfg_reg[scp_pkg::DEFAULT_SEL_BIT];

    always_comb begin
        rd_byte = 8'h00;
        case (i_wb_adr)
            scp_pkg::ADR_PLL_CTRL: begin
                rd_byte = {pll_reg[POST_IDX], mult_eff,
                    pll_reg[POST_EN_IDX], pll_reg[PRE_IDX], 4'h0};
            end
            scp_pkg::ADR_OSC_CTRL: begin
                rd_byte = {osc_reg[scp_pkg::IDLE_EN_BIT], 3'h0,
                    run_default, 1'b0, osc_reg[1:0]};
            end
            scp_pkg::ADR_FEATURES: begin
                rd_byte = {1'b0, cfg_reg, feat_reg};
            end
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0;
        end else begin
            o_wb_ack <= i_wb_cyc && i_wb_stb && !o_wb_ack;
            if (i_wb_cyc && i_wb_stb && !o_wb_ack && !i_wb_we) begin
                o_wb_dat <= {24'h0, rd_byte};
            end
        end
    end
endmodule

`default_nettype wire

// ---- verif/scp_clock_ctrl_properties.sv ----
/* port-level checker for the clock source and pll control block.
   assumes a bind onto scp_clock_ctrl, one i_mclk domain. */
`timescale 1ns/1ps
`default_nettype none
module scp_clock_ctrl_chk (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // bus
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [3:0] i_wb_adr,
    input wire logic [31:0] o_wb_dat,
    input wire logic o_wb_ack,
    // clock tree
    input wire logic o_osc_out_pin,
    input wire logic o_osc_out_oe_n,
    input wire logic o_feedback_en,
    input wire logic o_slow_osc_en,
    input wire logic o_config_loading,
    input wire logic o_primary_ready,
    input wire logic o_sysclk_run,
    input wire logic [1:0] o_active_src,
    input wire logic o_mult_en,
    input wire logic [1:0] o_pre_div,
    input wire logic [1:0] o_post_div
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    AST_ACK_NEXT: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack
        |=> o_wb_ack) else $error("ack missing after request");
    AST_ACK_SINGLE: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack longer than one cycle");
    AST_PLL_RD_ZERO: assert property (
        o_wb_ack && !i_wb_we && i_wb_adr == 4'h0 |-> o_wb_dat[3:0] == 4'h0
        && o_wb_dat[31:8] == 24'h0) else $error("pll read unused bits set");
    AST_OUT_IDLE: assert property (
        o_osc_out_oe_n |-> !o_osc_out_pin)
        else $error("out pin high while not driven");
    AST_OUT_SLOW: assert property (
        $rose(o_osc_out_pin) |=> o_osc_out_pin [*4])
        else $error("out pin toggles too fast");
    AST_FB_EXCL: assert property (o_feedback_en |-> o_osc_out_oe_n)
        else $error("feedback on in plain external mode");
    AST_LOAD_SLOW: assert property (
        o_config_loading |-> o_slow_osc_en) else $error("slow osc off in load");
    AST_PRE_BYPASS: assert property (
        !o_mult_en && o_post_div == 2'h1 |-> o_pre_div == 2'h1)
        else $error("pre divider not bypassed");
    AST_PRE_USED: assert property (
        o_mult_en || o_post_div != 2'h1 |-> o_pre_div inside {2'h2, 2'h3}
        && o_post_div != 2'h0) else $error("divider ratio out of range");
    AST_PLAIN_NOMULT: assert property (!o_osc_out_oe_n |-> !o_mult_en)
        else $error("multiplier on in plain external mode");
    AST_EXT_READY: assert property (
        !o_osc_out_oe_n && $past(!o_osc_out_oe_n) |-> o_primary_ready)
        else $error("external clock waits for start-up");
    AST_SRC_CODE: assert property (o_active_src != 2'h0)
        else $error("active source shows select code zero");
    AST_PAUSE: assert property (
        $fell(o_sysclk_run) |=> !o_sysclk_run [*4])
        else $error("switch pause too short");
endmodule
bind scp_clock_ctrl scp_clock_ctrl_chk scp_clock_ctrl_chk_inst (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_osc_out_pin(o_osc_out_pin),
    .o_osc_out_oe_n(o_osc_out_oe_n), .o_feedback_en(o_feedback_en),
    .o_slow_osc_en(o_slow_osc_en), .o_config_loading(o_config_loading),
    .o_primary_ready(o_primary_ready), .o_sysclk_run(o_sysclk_run),
    .o_active_src(o_active_src), .o_mult_en(o_mult_en),
    .o_pre_div(o_pre_div), .o_post_div(o_post_div));
`default_nettype wire

// ---- verif/scp_osc_model.sv ----
/* oscillator sources seen by the block: primary, timer, slow internal.
   assumes free-running waves; slow ones shortened to keep runs short. */
`timescale 1ns/1ps
`default_nettype none
module scp_osc_model (
    // oscillator waves
    output logic o_osc_in_pin,
    output logic o_timer_osc,
    output logic o_slow_internal_osc
);
    initial begin
        o_osc_in_pin = 1'b0;
        #3;
        forever #20 o_osc_in_pin = ~o_osc_in_pin;
    end
    // timer wave sped up; only its edges matter to the switch logic
    initial begin
        o_timer_osc = 1'b0;
        forever #50 o_timer_osc = ~o_timer_osc;
    end
    initial begin
        o_slow_internal_osc = 1'b0;
        #7;
        forever #150 o_slow_internal_osc = ~o_slow_internal_osc;
    end
endmodule
`default_nettype wire

// ---- verif/scp_clock_ctrl_bench.sv ----
/* self-checking bench for the clock source and pll control block.
   assumes the oscillator model and a bound port checker. */
`timescale 1ns/1ps
`default_nettype none
module scp_clock_ctrl_bench;
    logic i_mclk, i_sys_rst, cyc, stb, we, ack, sleep, osc_in, tmr, slow;
    logic out_pin, out_oe_n, fb, slow_en, loading, ready, run, mult, pin0;
    logic [3:0] adr, sel;
    logic [31:0] wdat, rdat, r;
    logic [2:0] cfg;
    logic [1:0] src, pre, post;
    logic [31:0] exp_q[$];
    int failures, checked, seed, k;
    logic [7:0] pat [11] = '{8'hf0, 8'h70, 8'h40, 8'he0, 8'h60, 8'h00,
        8'hb0, 8'h30, 8'ha0, 8'h20, 8'h10};
    logic [4:0] dv [11] = '{5'h1a, 5'h1b, 5'h1d, 5'h1e, 5'h1f, 5'h05,
        5'h0a, 5'h0b, 5'h0e, 5'h0f, 5'h05};
    scp_osc_model scp_osc_model_inst (.o_osc_in_pin(osc_in),
        .o_timer_osc(tmr), .o_slow_internal_osc(slow));
    scp_clock_ctrl #(.START_EDGES(8)) scp_clock_ctrl_inst (.i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(rdat),
        .o_wb_ack(ack), .i_osc_config(cfg), .i_sleep(sleep),
        .i_osc_in_pin(osc_in), .i_timer_osc(tmr), .i_slow_internal_osc(slow),
        .o_osc_out_pin(out_pin), .o_osc_out_oe_n(out_oe_n),
        .o_feedback_en(fb), .o_slow_osc_en(slow_en),
        .o_config_loading(loading), .o_primary_ready(ready),
        .o_sysclk_run(run), .o_active_src(src), .o_mult_en(mult),
        .o_pre_div(pre), .o_post_div(post));
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    task automatic fail_msg(input logic [31:0] got, input logic [31:0] exp);
        failures++;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    endtask
    task automatic cmp_sig(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) fail_msg({24'h0, got}, {24'h0, exp});
    endtask
    task automatic cmp_dat(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) fail_msg(got, exp);
    endtask
    // read results are matched against the oldest pending note
    always @(posedge i_mclk) begin
        if (ack === 1'b1 && we === 1'b0) begin
            if (exp_q.size() == 0) fail_msg(rdat, 32'h0);
            else cmp_dat(rdat, exp_q.pop_front());
        end
    end
    task automatic wb(input logic [3:0] a, input logic w,
        input logic [31:0] d);
        adr <= a;
        we <= w;
        wdat <= d;
        cyc <= 1'b1;
        stb <= 1'b1;
        @(posedge i_mclk);
        // no local limit: the watchdog ends a hung wait
        while (ack !== 1'b1) @(posedge i_mclk);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge i_mclk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        wb(a, 1'b0, $random(seed));
    endtask
    task automatic reset_to(input logic [2:0] c);
        cfg <= c;
        i_sys_rst <= 1'b1;
        repeat (8) @(posedge i_mclk);
        cmp_sig({7'h0, loading}, 8'h1);
        i_sys_rst <= 1'b0;
        repeat (4) @(posedge i_mclk);
        cmp_sig({7'h0, loading}, 8'h0);
    endtask
    task automatic wait_src(input logic [1:0] s);
        int n;
        n = 0;
        while (src !== s && n < 300) begin
            @(posedge i_mclk);
            n++;
        end
        cmp_sig({6'h0, src}, {6'h0, s});
    endtask
    task automatic test_end(input string name);
        $display("test %s finished", name);
    endtask
    task automatic print_verdict();
        if (exp_q.size() != 0) failures++;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #100000;
        failures++;
        print_verdict();
    end
    initial begin
        seed = 32'h587f;
        failures = 0;
        checked = 0;
        i_sys_rst = 1'b1;
        {cyc, stb, we, sleep} = 4'h0;
        adr = 4'h0;
        wdat = 32'h0;
        sel = 4'hf;
        cfg = 3'h3;
        reset_to(3'h3);
        cmp_sig({7'h0, ready}, 8'h1);
        cmp_sig({7'h0, fb}, 8'h0);
        cmp_sig({6'h0, src}, 8'h3);
        cmp_sig({7'h0, slow_en}, 8'h1);
        rd(4'h0, 32'h0);
        rd(4'h8, 32'h30);
        // patterns leave out the reserved x101 setting
        for (int i = 0; i < 11; i++) begin
            r = $random(seed);
            wb(4'h0, 1'b1, {r[31:8], pat[i][7:4], r[3:0]});
            cmp_sig({7'h0, mult}, {7'h0, dv[i][4]});
            cmp_sig({6'h0, pre}, {6'h0, dv[i][3:2]});
            cmp_sig({6'h0, post}, {6'h0, dv[i][1:0]});
            rd(4'h0, {24'h0, pat[i]});
        end
        test_end("ratios");
        wb(4'h4, 1'b1, 32'h2);
        wait_src(2'h2);
        cmp_sig({7'h0, slow_en}, 8'h0);
        // timer select is refused while its oscillator is off
        wb(4'h4, 1'b1, 32'h1);
        repeat (100) @(posedge i_mclk);
        cmp_sig({6'h0, src}, 8'h2);
        wb(4'h8, 1'b1, 32'h8);
        wb(4'h4, 1'b1, 32'h1);
        wait_src(2'h1);
        wb(4'h8, 1'b1, 32'h9);
        repeat (4) @(posedge i_mclk);
        cmp_sig({7'h0, slow_en}, 8'h1);
        wb(4'h4, 1'b1, 32'h0);
        wait_src(2'h3);
        test_end("switch");
        reset_to(3'h6);
        cmp_sig({7'h0, out_oe_n}, 8'h0);
        cmp_sig({7'h0, fb}, 8'h0);
        wait_src(2'h2);
        cmp_sig({7'h0, slow_en}, 8'h0);
        pin0 = out_pin;
        k = 0;
        repeat (160) begin
            @(posedge i_mclk);
            if (out_pin && !pin0) k++;
            pin0 = out_pin;
        end
        cmp_sig({7'h0, k >= 9 && k <= 11}, 8'h1);
        sleep <= 1'b1;
        repeat (20) @(posedge i_mclk);
        cmp_sig({7'h0, ready}, 8'h1);
        sleep <= 1'b0;
        // a write without byte lane 0 must not store
        sel <= 4'he;
        wb(4'h0, 1'b1, 32'hf0);
        sel <= 4'hf;
        rd(4'h0, 32'h0);
        wb(4'h0, 1'b1, 32'hf0);
        rd(4'h0, 32'hb0);
        cmp_sig({7'h0, mult}, 8'h0);
        test_end("plain external");
        reset_to(3'h4);
        cmp_sig({7'h0, fb}, 8'h1);
        cmp_sig({7'h0, ready}, 8'h0);
        k = 0;
        while (ready !== 1'b1 && k < 300) begin
            @(posedge i_mclk);
            k++;
        end
        wait_src(2'h2);
        cmp_sig({6'h0, ready, run}, 8'h3);
        test_end("crystal");
        // crystal with multiplier keeps the multiplier bit usable
        reset_to(3'h5);
        cmp_sig({7'h0, fb}, 8'h1);
        wb(4'h0, 1'b1, 32'hf0);
        cmp_sig({7'h0, mult}, 8'h1);
        rd(4'h0, 32'hf0);
        test_end("crystal multiplied");
        print_verdict();
    end
endmodule
`default_nettype wire
